// ---- rtl/ddc_pkg.sv ----
// Constants, carrier types and shared arithmetic of the down converter
package ddc_pkg;
    // ********************************************************
    // Widths and latencies
    // ********************************************************
    localparam int SAMPLE_W = 12;
    localparam int MIX_W = 16;
    localparam int OUT_W = 15;
    localparam int MIX_SHIFT = 8;
    localparam int SYNC_STAGES = 3;
    localparam int ADC_MIXER_CYCLES = 37;
    localparam int SAMPLE_DELAY = ADC_MIXER_CYCLES - 1;
    localparam int GPIO_MIXER_MIN = 45;
    localparam int GPIO_MIXER_MAX = 68;
    localparam int HOP_DELAY = 44;
    // ********************************************************
    // Register map and fields
    // ********************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_RDIV = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [2:0] REG_FREQ_PAGE = 3'h2;
    localparam logic [2:0] REG_PHASE_PAGE = 3'h3;
    localparam int CTRL_DDC_EN = 0;
    localparam int CTRL_SINGLE = 1;
    localparam int CTRL_SRC = 2;
    localparam int CTRL_DEC8 = 3;
    localparam int CTRL_SOFT_A = 4;
    localparam int CTRL_SOFT_B = 6;
    localparam int CTRL_BIND_A = 8;
    localparam int CTRL_BIND_B = 9;
    localparam logic [9:0] CTRL_RESET = 10'h200;
    localparam logic [15:0] RDIV_RESET = 16'h0000;
    localparam logic [31:0] FREQ_RESET = 32'h0000_0000;
    localparam logic [15:0] PHASE_RESET = 16'h0000;
    // ********************************************************
    // Carriers
    // ********************************************************
    typedef struct packed {
        logic signed [11:0] cos_v;
        logic signed [11:0] sin_v;
    } osc_t;
    typedef struct packed {
        logic signed [15:0] i;
        logic signed [15:0] q;
    } cplx_t;
    typedef struct packed {
        logic valid;
        logic bypass;
        logic signed [14:0] i;
        logic signed [14:0] q;
    } ddc_out_t;
    // ********************************************************
    // Arithmetic
    // ********************************************************
    function automatic logic [10:0] quarter_sine(input logic [4:0] k);
        case (k)
            5'h00: return 11'h000;
            5'h01: return 11'h0C9;
            5'h02: return 11'h18F;
            5'h03: return 11'h252;
            5'h04: return 11'h30F;
            5'h05: return 11'h3C5;
            5'h06: return 11'h471;
            5'h07: return 11'h513;
            5'h08: return 11'h5A7;
            5'h09: return 11'h62E;
            5'h0A: return 11'h6A6;
            5'h0B: return 11'h70D;
            5'h0C: return 11'h763;
            5'h0D: return 11'h7A7;
            5'h0E: return 11'h7D8;
            5'h0F: return 11'h7F5;
            default: return 11'h7FF;
        endcase
    endfunction
    function automatic logic signed [11:0] sine(input logic [5:0] p);
        logic [4:0] k;
        logic [11:0] m;
        k = p[4] ? 5'h10 - {1'b0, p[3:0]} : {1'b0, p[3:0]};
        m = {1'b0, quarter_sine(k)};
        return p[5] ? -m : m;
    endfunction
    function automatic osc_t osc_lookup(input logic [5:0] p);
        osc_t o;
        o.sin_v = sine(p);
        o.cos_v = sine(p + 6'h10);
        return o;
    endfunction
    // Round to nearest, ties to even
    function automatic logic signed [39:0] conv_round(
        input logic signed [39:0] v, input int sh);
        logic signed [39:0] q;
        logic [39:0] frac;
        logic [39:0] half;
        q = v >>> sh;
        frac = v & ((40'h1 << sh) - 40'h1);
        half = 40'h1 << (sh - 1);
        if (frac > half || (frac == half && q[0])) begin
            q = q + 40'sh1;
        end
        return q;
    endfunction
    function automatic logic signed [15:0] sat(
        input logic signed [39:0] v, input int bits);
        logic signed [39:0] hi;
        hi = (40'sh1 <<< (bits - 1)) - 40'sh1;
        if (v > hi) begin
            return hi[15:0];
        end
        if (v < -hi - 40'sh1) begin
            return 16'(-hi - 40'sh1);
        end
        return v[15:0];
    endfunction
endpackage

// ---- rtl/nco_bank.sv ----
// Four free-running oscillators of one down converter
`timescale 1ns/1ps
module nco_bank (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [3:0][31:0] i_freq_word,
    input wire logic [3:0][15:0] i_phase_word,
    input wire logic [1:0] i_osc_index,
    output ddc_pkg::osc_t o_osc
);
    logic [3:0][31:0] acc;
    wire [31:0] phase_sel = acc[i_osc_index]
        + {i_phase_word[i_osc_index], 16'h0000}; // RULE17

    // All four advance every cycle, selected or not
    always_ff @(posedge i_sys_clk) begin
        for (int k = 0; k < 4; k++) begin
            if (i_sys_rst) begin
                acc[k] <= '0; // RULE20
            end else begin
                acc[k] <= acc[k] + i_freq_word[k]; // RULE10 RULE16
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_osc <= '0;
        end else begin
            o_osc <= ddc_pkg::osc_lookup(phase_sel[31:26]); // RULE7
        end
    end

    for (genvar k = 0; k < 4; k++) begin : g_chk
        AST_ACC_RUN: assert property (@(posedge i_sys_clk) // RULE10
            disable iff (i_sys_rst) !$past(i_sys_rst) |->
            acc[k] == $past(acc[k]) + $past(i_freq_word[k]))
            else $error("oscillator accumulator stalled");
        AST_ACC_RESET: assert property (@(posedge i_sys_clk) // RULE20
            $past(i_sys_rst) |-> acc[k] == 32'h0000_0000)
            else $error("accumulator not cleared by reset");
    end
endmodule

// ---- rtl/decim_fir.sv ----
// Boxcar decimating filter with one rounding at the output
`timescale 1ns/1ps
module decim_fir (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_active,
    input wire logic i_dec8,
    input ddc_pkg::cplx_t i_mix,
    output ddc_pkg::ddc_out_t o_out
);
    logic signed [18:0] acc_i;
    logic signed [18:0] acc_q;
    logic [2:0] cnt;
    wire last = cnt == (i_dec8 ? 3'h7 : 3'h3);
    wire signed [39:0] sum_i = 40'(acc_i) + 40'(i_mix.i);
    wire signed [39:0] sum_q = 40'(acc_q) + 40'(i_mix.q);
    wire [1:0] sh = i_dec8 ? 2'h3 : 2'h2;

    // Filter and decimation are one step: dump the sum every 4th or 8th
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || !i_active) begin
            acc_i <= '0;
            acc_q <= '0;
            cnt <= '0;
            o_out <= '0;
        end else if (last) begin
            acc_i <= '0;
            acc_q <= '0;
            cnt <= '0;
            o_out.valid <= 1'b1;
            o_out.bypass <= 1'b0;
            o_out.i <= 15'(ddc_pkg::sat(
                ddc_pkg::conv_round(sum_i, sh), 15)); // RULE5 RULE6
            o_out.q <= 15'(ddc_pkg::sat(
                ddc_pkg::conv_round(sum_q, sh), 15)); // RULE5 RULE6
        end else begin
            acc_i <= sum_i[18:0]; // RULE6
            acc_q <= sum_q[18:0]; // RULE6
            cnt <= cnt + 3'h1;
            o_out.valid <= 1'b0;
        end
    end

    AST_DEC_GAP: assert property (@(posedge i_sys_clk) // RULE18
        disable iff (i_sys_rst) o_out.valid && i_active && !i_dec8
        && $stable(i_dec8) |=> !o_out.valid [*3])
        else $error("decimate-by-4 output came too soon");
endmodule

// ---- rtl/ddc_top.sv ----
// Down converter pair: register port, hop pins, mixers and decimators
//
// What this block does
// [RULE1] Samples go to the output directly in bypass, else through mixing.
// [RULE2] Works dual or single channel; single channel leaves only one DDC.
// [RULE3] Mix to baseband with the oscillator, then filter-decimate in one step.
// [RULE4] In dual channel, each DDC picks channel A or B by its select bit.
// [RULE5] Reductions round to nearest, ties to even, and saturate.
// [RULE6] Filters keep full precision and round only at the output.
// [RULE7] Each oscillator makes a complex exponential from a 32-bit word.
// [RULE8] Real samples times the complex sequence shift a tone by f_osc.
// [RULE9] Four oscillators per DDC, each with frequency and phase, pin chosen.
// [RULE10] Every accumulator keeps advancing while unselected.
// [RULE11] Hop pins are asynchronous; a change switches the oscillator.
// [RULE12] Pin selection reaches mixer about 45-68 cycles; samples about 37.
// [RULE13] Source bit 1 selects pins, 0 (default) selects the software field.
// [RULE14] Active two-bit selector is a binary index 0..3; other is ignored.
// [RULE15] Each oscillator has its own frequency and phase word.
// [RULE16] Oscillator frequency is word times 2^-32 times clock rate.
// [RULE17] Phase word is left-justified to 32 bits, added to accumulator.
// [RULE18] Complex decimation by 4 or 8 to 15-bit outputs.
// [RULE19] Hop pins pass a multi-stage synchroniser before use.
// [RULE20] Reset clears accumulators and selects oscillator 0 in software.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module ddc_top (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic signed [11:0] i_adc_a_sample,
    input wire logic signed [11:0] i_adc_b_sample,
    input wire logic [1:0] i_ddc_a_hop_pins,
    input wire logic [1:0] i_ddc_b_hop_pins,
    output ddc_pkg::ddc_out_t o_ddc_a,
    output ddc_pkg::ddc_out_t o_ddc_b
);
    localparam int HOP_N = ddc_pkg::HOP_DELAY;
    localparam int SAMP_N = ddc_pkg::SAMPLE_DELAY;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst);

    // ********************************************************
    // Register file
    // ********************************************************
    logic [9:0] ctrl;
    logic [15:0] rational_freq_divider;
    logic [1:0][3:0][31:0] freq_word;
    logic [1:0][3:0][15:0] phase_word;

    wire ddc_en = ctrl[ddc_pkg::CTRL_DDC_EN];
    wire single_mode = ctrl[ddc_pkg::CTRL_SINGLE];
    wire osc_select_source = ctrl[ddc_pkg::CTRL_SRC];
    wire dec8 = ctrl[ddc_pkg::CTRL_DEC8];
    wire [1:0] ddc_a_soft_osc_select =
        ctrl[ddc_pkg::CTRL_SOFT_A +: 2];
    wire [1:0] ddc_b_soft_osc_select =
        ctrl[ddc_pkg::CTRL_SOFT_B +: 2];
    wire ddc_input_channel_select = ctrl[ddc_pkg::CTRL_BIND_A];
    wire ddc_b_input_channel_select = ctrl[ddc_pkg::CTRL_BIND_B];

    wire hit_ctrl = i_addr == ddc_pkg::REG_CTRL;
    wire hit_rdiv = i_addr == ddc_pkg::REG_RDIV;
    wire hit_status = i_addr == ddc_pkg::REG_STATUS;
    wire hit_freq = i_addr[7:5] == ddc_pkg::REG_FREQ_PAGE;
    wire hit_phase = i_addr[7:5] == ddc_pkg::REG_PHASE_PAGE;
    wire word_ddc = i_addr[4];
    wire [1:0] word_osc = i_addr[3:2];
    wire aligned = i_addr[1:0] == 2'h0;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            ctrl <= ddc_pkg::CTRL_RESET; // RULE20
            rational_freq_divider <= ddc_pkg::RDIV_RESET;
        end else if (i_wr && aligned && hit_ctrl) begin
            ctrl <= i_wdata[9:0];
        end else if (i_wr && aligned && hit_rdiv) begin
            rational_freq_divider <= i_wdata[15:0];
        end
    end

    // Each oscillator has its own words
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            freq_word <= {8{ddc_pkg::FREQ_RESET}};
            phase_word <= {8{ddc_pkg::PHASE_RESET}};
        end else if (i_wr && aligned && hit_freq) begin
            freq_word[word_ddc][word_osc] <= i_wdata; // RULE15
        end else if (i_wr && aligned && hit_phase) begin
            phase_word[word_ddc][word_osc] <= i_wdata[15:0]; // RULE15
        end
    end

    // ********************************************************
    // Hop pin synchronisers
    // ********************************************************
    logic [1:0][1:0] hop_s1;
    logic [1:0][1:0] hop_s2;
    logic [1:0][1:0] hop_s3;
    logic [1:0][1:0] pin_sel;
    logic [1:0][HOP_N-1:0][1:0] pin_dly;

    // Both bits must agree in stages two and three, so a pin pair
    // caught mid-change never yields a stray oscillator index
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            hop_s1 <= '0;
            hop_s2 <= '0;
            hop_s3 <= '0;
            pin_sel <= '0;
        end else begin
            hop_s1 <= {i_ddc_b_hop_pins, i_ddc_a_hop_pins}; // RULE19
            hop_s2 <= hop_s1; // RULE19
            hop_s3 <= hop_s2; // RULE19
            for (int d = 0; d < 2; d++) begin
                if (hop_s2[d] == hop_s3[d]) begin
                    pin_sel[d] <= hop_s3[d]; // RULE11 RULE19
                end
            end
        end
    end

    // Pads the pin path so a hop lands at the mixer in the stated window
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            pin_dly <= '0;
        end else begin
            for (int d = 0; d < 2; d++) begin
                pin_dly[d][0] <= pin_sel[d]; // RULE12
                for (int s = 1; s < HOP_N; s++) begin
                    pin_dly[d][s] <= pin_dly[d][s-1]; // RULE12
                end
            end
        end
    end

    wire [1:0] soft_sel [2] = '{ddc_a_soft_osc_select,
        ddc_b_soft_osc_select};
    wire [1:0] osc_index [2];
    assign osc_index[0] = osc_select_source ? pin_dly[0][HOP_N-1]
        : soft_sel[0]; // RULE13 RULE14
    assign osc_index[1] = osc_select_source ? pin_dly[1][HOP_N-1]
        : soft_sel[1]; // RULE13 RULE14

    // ********************************************************
    // Input selection and sample alignment
    // ********************************************************
    wire signed [11:0] ddc_in [2];
    assign ddc_in[0] = (!single_mode && ddc_input_channel_select)
        ? i_adc_b_sample : i_adc_a_sample; // RULE4
    assign ddc_in[1] = ddc_b_input_channel_select
        ? i_adc_b_sample : i_adc_a_sample; // RULE4
    wire [1:0] ddc_active;
    assign ddc_active[0] = ddc_en;
    assign ddc_active[1] = ddc_en && !single_mode; // RULE2

    logic signed [1:0][SAMP_N-1:0][11:0] samp_dly;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            samp_dly <= '0;
        end else begin
            for (int d = 0; d < 2; d++) begin
                samp_dly[d][0] <= ddc_in[d]; // RULE12
                for (int s = 1; s < SAMP_N; s++) begin
                    samp_dly[d][s] <= samp_dly[d][s-1]; // RULE12
                end
            end
        end
    end

    // ********************************************************
    // Oscillators, mixers and decimators
    // ********************************************************
    ddc_pkg::osc_t osc [2];
    ddc_pkg::cplx_t mix [2];
    ddc_pkg::ddc_out_t dec_out [2];
    ddc_pkg::ddc_out_t out_r [2];

    for (genvar d = 0; d < 2; d++) begin : g_ddc
        wire signed [11:0] x = samp_dly[d][SAMP_N-1];
        wire signed [39:0] prod_i = 40'(x * osc[d].cos_v);
        wire signed [39:0] prod_q = 40'(x * osc[d].sin_v);

        nco_bank u_nco (
            .i_sys_clk(i_sys_clk),
            .i_sys_rst(i_sys_rst),
            .i_freq_word(freq_word[d]),
            .i_phase_word(phase_word[d]),
            .i_osc_index(osc_index[d]), // RULE9
            .o_osc(osc[d])
        );

        // Real times complex moves a tone up by the oscillator frequency
        always_ff @(posedge i_sys_clk) begin
            if (i_sys_rst) begin
                mix[d] <= '0;
            end else begin
                mix[d].i <= ddc_pkg::sat(ddc_pkg::conv_round(prod_i,
                    ddc_pkg::MIX_SHIFT), ddc_pkg::MIX_W); // RULE5 RULE8
                mix[d].q <= ddc_pkg::sat(ddc_pkg::conv_round(prod_q,
                    ddc_pkg::MIX_SHIFT), ddc_pkg::MIX_W); // RULE5 RULE8
            end
        end

        decim_fir u_dec (
            .i_sys_clk(i_sys_clk),
            .i_sys_rst(i_sys_rst),
            .i_active(ddc_active[d]), // RULE3
            .i_dec8(dec8), // RULE18
            .i_mix(mix[d]),
            .o_out(dec_out[d])
        );
    end

    // Bypass drives channel A's raw sample out on every cycle, and channel B's in dual channel only
    wire signed [11:0] raw [2] = '{i_adc_a_sample, i_adc_b_sample};

    always_ff @(posedge i_sys_clk) begin
        for (int d = 0; d < 2; d++) begin
            if (i_sys_rst || (d == 1 && single_mode)) begin
                out_r[d] <= '0; // RULE2
            end else if (!ddc_en) begin
                out_r[d].valid <= 1'b1; // RULE1
                out_r[d].bypass <= 1'b1;
                out_r[d].i <= 15'(raw[d]); // RULE1
                out_r[d].q <= '0;
            end else begin
                out_r[d] <= dec_out[d]; // RULE1 RULE3
            end
        end
    end
    assign o_ddc_a = out_r[0];
    assign o_ddc_b = out_r[1];

    // ********************************************************
    // Read port
    // ********************************************************
    wire [31:0] status_word = {24'h0, osc_index[1], osc_index[0],
        pin_sel[1], pin_sel[0]};
    wire [31:0] rd_mux =
        !aligned ? 32'h0000_0000 :
        hit_ctrl ? {22'h0, ctrl} :
        hit_rdiv ? {16'h0, rational_freq_divider} :
        hit_status ? status_word :
        hit_freq ? freq_word[word_ddc][word_osc] :
        hit_phase ? {16'h0, phase_word[word_ddc][word_osc]} :
        32'h0000_0000;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || !i_rd) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= rd_mux;
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    // Deep history looks are trusted only once the pipes have refilled
    // after reset, and a hop only once the source bit has settled
    logic [7:0] up_run;
    logic [7:0] src_run;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            up_run <= '0;
            src_run <= '0;
        end else begin
            up_run <= up_run + {7'h00, up_run != 8'hFF};
            src_run <= osc_select_source
                ? src_run + {7'h00, src_run != 8'hFF} : 8'h00;
        end
    end

    AST_BYPASS_PASS: assert property (!ddc_en && !single_mode // RULE1
        && !$past(i_sys_rst) |=> o_ddc_a.valid && o_ddc_a.bypass
        && o_ddc_a.i == 15'($past(i_adc_a_sample)))
        else $error("bypass sample not forwarded");
    AST_BYPASS_B: assert property (!ddc_en && !single_mode // RULE1
        && !$past(i_sys_rst) |=> o_ddc_b.valid && o_ddc_b.bypass
        && o_ddc_b.i == 15'($past(i_adc_b_sample)))
        else $error("second bypass sample not forwarded");
    AST_SINGLE_B_OFF: assert property ( // RULE2
        single_mode |=> !o_ddc_b.valid)
        else $error("second converter active in single channel");
    AST_SINGLE_A_SRC: assert property ( // RULE2
        single_mode |=> samp_dly[0][0] == $past(i_adc_a_sample))
        else $error("single channel converter not on channel A");
    AST_BIND_A: assert property (ddc_en && !single_mode |=> // RULE4
        samp_dly[0][0] == ($past(ddc_input_channel_select)
        ? $past(i_adc_b_sample) : $past(i_adc_a_sample)))
        else $error("converter A took the wrong channel");
    AST_BIND_B: assert property (!single_mode |=> // RULE4
        samp_dly[1][0] == ($past(ddc_b_input_channel_select)
        ? $past(i_adc_b_sample) : $past(i_adc_a_sample)))
        else $error("converter B took the wrong channel");
    AST_SOFT_SEL: assert property (!osc_select_source |-> // RULE13
        osc_index[0] == ddc_a_soft_osc_select
        && osc_index[1] == ddc_b_soft_osc_select)
        else $error("software select not applied");
    AST_PIN_SEL: assert property (osc_select_source |-> // RULE14
        osc_index[1] == $past(pin_sel[1], HOP_N))
        else $error("pin select not applied");
    // The new index must appear exactly at the padded landing cycle
    AST_HOP_DELAY: assert property ($changed(pin_sel[0]) // RULE12
        ##HOP_N src_run > 8'(HOP_N) |-> $changed(osc_index[0])
        && osc_index[0] == $past(pin_sel[0], HOP_N))
        else $error("hop reached mixer at the wrong cycle");
    AST_HOP_DELAY_B: assert property ($changed(pin_sel[1]) // RULE11
        ##HOP_N src_run > 8'(HOP_N) |-> $changed(osc_index[1]))
        else $error("second converter missed a hop");
    AST_SYNC_AGREE: assert property ($changed(pin_sel[0]) |-> // RULE19
        $past(hop_s2[0]) == $past(hop_s3[0]))
        else $error("selection moved on a disputed pin value");
    AST_SYNC_AGREE_B: assert property ($changed(pin_sel[1]) |-> // RULE19
        $past(hop_s2[1]) == $past(hop_s3[1]))
        else $error("second selection moved on a disputed pin value");
    AST_SAMPLE_LAT: assert property (up_run > 8'(SAMP_N) |-> // RULE12
        samp_dly[1][SAMP_N-1] == $past(ddc_in[1], SAMP_N))
        else $error("sample latency to mixer is wrong");
    AST_SAMPLE_LAT_A: assert property (up_run > 8'(SAMP_N) |-> // RULE12
        samp_dly[0][SAMP_N-1] == $past(ddc_in[0], SAMP_N))
        else $error("first sample latency to mixer is wrong");
    AST_RESET_SEL: assert property ($past(i_sys_rst) |-> // RULE20
        !osc_select_source && ddc_a_soft_osc_select == 2'h0)
        else $error("reset does not select oscillator 0");

    // Main scenarios: hops on both converters, both rates, bypass
    COV_HOP: cover property (osc_select_source && $changed(pin_sel[0]));
    COV_HOP_B: cover property (osc_select_source && $changed(pin_sel[1]));
    COV_DEC4: cover property (o_ddc_a.valid && !o_ddc_a.bypass && !dec8);
    COV_DEC8: cover property (o_ddc_b.valid && !o_ddc_b.bypass && dec8);
    COV_BYPASS: cover property (o_ddc_a.valid && o_ddc_a.bypass);
endmodule

// ---- verification/ddc_out_sink.sv ----
// Receiver model at the output stream: measures spacing of valid words
`timescale 1ns/1ps
module ddc_out_sink (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input ddc_pkg::ddc_out_t i_word,
    output logic [7:0] o_gap
);
    logic [7:0] run;
    // The receiver never stalls the stream, so only spacing is observable
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || i_word.valid) begin
            run <= 8'h01;
        end else begin
            run <= run + 8'h01;
        end
        if (!i_sys_rst && i_word.valid) begin
            o_gap <= run;
        end
    end
endmodule

// ---- verification/test_ddc_top.sv ----
// Self-checking bench of the down converter pair
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        n_compared++; \
        if ((g) !== (e)) begin \
            fails++; \
            $display("Error %s expected %h seen %h", nm, e, g); \
        end \
    end
module test_ddc_top;
    typedef struct {
        logic [9:0] ctrl;
        logic signed [11:0] xa, xb;
        logic [14:0] ei, eq, eb;
        logic [7:0] eg;
    } row_t;
    typedef struct {logic [7:0] a; logic [31:0] d, e;} reg_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [31:0] rdata;
    logic signed [11:0] xa = 12'h000;
    logic signed [11:0] xb = 12'h000;
    logic [1:0] pa = 2'h0;
    logic [1:0] pb = 2'h0;
    ddc_pkg::ddc_out_t out_a, out_b;
    logic [7:0] gap_a;
    int fails = 0;
    int n_compared = 0;
    row_t rows [11] = '{
        '{10'h200,12'hFFB,12'h123,15'h7FFB,15'h0,15'h0123,8'h01},
        '{10'h000,12'h7FF,12'h123,15'h07FF,15'h0,15'h0123,8'h01},
        '{10'h002,12'hC00,12'h123,15'h7C00,15'h0,15'h0,8'h01},
        '{10'h201,12'h064,12'h064,15'h0320,15'h0,15'h0320,8'h04},
        '{10'h201,12'h080,12'h080,15'h0400,15'h0,15'h0400,8'h04},
        '{10'h201,12'h180,12'h180,15'h0BFE,15'h0,15'h0BFE,8'h04},
        '{10'h201,12'h800,12'h800,15'h4008,15'h0,15'h4008,8'h04},
        '{10'h209,12'h064,12'h064,15'h0320,15'h0,15'h0320,8'h08},
        '{10'h211,12'h064,12'h064,15'h0,15'h0320,15'h0320,8'h04},
        '{10'h221,12'h064,12'h064,15'h0,15'h0,15'h0320,8'h04},
        '{10'h003,12'h064,12'h123,15'h0320,15'h0,15'h0,8'h04}};
    reg_row_t regs [8] = '{
        '{8'h04,32'h0000_1234,32'h0000_1234},
        '{8'h58,32'h89AB_CDEF,32'h89AB_CDEF},
        '{8'h7C,32'h0000_ABCD,32'h0000_ABCD},
        '{8'h64,32'h0000_4000,32'h0000_4000},
        '{8'h48,32'h4000_0000,32'h4000_0000},
        '{8'h08,32'h0000_00FF,32'h0000_0000},
        '{8'h0C,32'h0000_0001,32'h0000_0000},
        '{8'h41,32'h0000_0001,32'h0000_0000}};
    ddc_top DUT (.i_sys_clk(clk), .i_sys_rst(rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
        .i_adc_a_sample(xa), .i_adc_b_sample(xb), .i_ddc_a_hop_pins(pa),
        .i_ddc_b_hop_pins(pb), .o_ddc_a(out_a), .o_ddc_b(out_b));
    ddc_out_sink sink_a (.i_sys_clk(clk), .i_sys_rst(rst), .i_word(out_a),
        .o_gap(gap_a));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        `CHK("rdata", e, rdata)
    endtask
    task automatic wait_v(input bit b, input int pre);
        int n;
        n = 0;
        repeat (pre) @(posedge clk);
        #1;
        while ((b ? out_b.valid : out_a.valid) !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 20) fails++;
    endtask
    function automatic logic [31:0] st(input logic [1:0] p, q, ia, ib);
        return {24'h0, ib, ia, q, p};
    endfunction
    task automatic final_report;
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rchk(8'h00, 32'h0000_0200);
        rchk(8'h6C, 32'h0000_0000);
        rchk(8'h08, 32'h0000_0000);
        foreach (regs[k]) begin
            wr(regs[k].a, regs[k].d);
            rchk(regs[k].a, regs[k].e);
        end
        foreach (rows[k]) begin
            wr(8'h00, 32'(rows[k].ctrl));
            xa <= rows[k].xa;
            xb <= rows[k].xb;
            wait_v(1'b0, 60);
            wait_v(1'b0, 1);
            `CHK("a_i", rows[k].ei, out_a.i)
            if (rows[k].ctrl[0]) `CHK("a_q", rows[k].eq, out_a.q)
            `CHK("gap", rows[k].eg, gap_a)
            if (rows[k].ctrl[1]) `CHK("b_out", 32'h0, out_b)
            else begin
                wait_v(1'b1, 0);
                `CHK("b_i", rows[k].eb, out_b.i)
            end
        end
        wr(8'h00, 32'h0000_0204);
        for (int k = 1; k < 5; k++) begin
            pa <= 2'(k);
            pb <= 2'(3 - k);
            repeat (37) @(posedge clk);
            rchk(8'h08, st(2'(k), 2'(3 - k), 2'(k - 1),
                k == 1 ? 2'h0 : 2'(4 - k)));
            repeat (26) @(posedge clk);
            rchk(8'h08, st(2'(k), 2'(3 - k), 2'(k), 2'(3 - k)));
        end
        wr(8'h00, 32'h0000_02D0);
        rchk(8'h08, 32'h0000_00DC);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rchk(8'h00, 32'h0000_0200);
        rchk(8'h64, 32'h0000_0000);
        final_report();
    end
    // Whole run is near 1050 cycles; the limit leaves ample margin
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        final_report();
    end
endmodule
